// file: pkg/tcm_pkg.sv
package tcm_pkg;

  // ----------------------------------------------------------------
  // Widths and extreme counter values
  // ----------------------------------------------------------------
  localparam int CNT_W = 8;
  localparam int CS_W = 3;
  localparam int PRESCALE_W = 10;
  localparam logic [7:0] CNT_BOTTOM = 8'h00;
  localparam logic [7:0] CNT_MAX = 8'hff;
  localparam logic [7:0] COUNT_RST = 8'h00;
  localparam logic [7:0] COMPARE_RST = 8'h00;
  localparam logic OC_RST = 1'b0;

  // ----------------------------------------------------------------
  // Prescale taps: divide by 8, 64, 256, 1024
  // ----------------------------------------------------------------
  localparam logic [9:0] DIV8_MASK = 10'h007;
  localparam logic [9:0] DIV64_MASK = 10'h03f;
  localparam logic [9:0] DIV256_MASK = 10'h0ff;
  localparam logic [9:0] DIV1024_MASK = 10'h3ff;

  // ----------------------------------------------------------------
  // Mode encodings
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    CS_STOP = 3'b000,
    CS_DIV1 = 3'b001,
    CS_DIV8 = 3'b010,
    CS_DIV64 = 3'b011,
    CS_DIV256 = 3'b100,
    CS_DIV1024 = 3'b101,
    CS_EXT_FALL = 3'b110,
    CS_EXT_RISE = 3'b111
  } tcm_clock_select_type;

  typedef enum logic [1:0] {
    WGM_NORMAL = 2'b00,
    WGM_PC_PWM = 2'b01,
    WGM_CTC = 2'b10,
    WGM_FAST_PWM = 2'b11
  } tcm_wgm_type;

  typedef enum logic [1:0] {
    COM_NONE = 2'b00,
    COM_TOGGLE = 2'b01,
    COM_CLEAR = 2'b10,
    COM_SET = 2'b11
  } tcm_com_type;

  // ----------------------------------------------------------------
  // Grouped control and status
  // ----------------------------------------------------------------
  typedef struct packed {
    tcm_clock_select_type clock_select;
    tcm_wgm_type waveform_gen_mode;
    tcm_com_type compare_output_mode;
  } tcm_ctrl_type;

  typedef struct packed {
    logic overflow_flag;
    logic compare_flag;
  } tcm_flags_type;

endpackage

// file: hw/tcm_prescaler.sv
`timescale 1ns/10ps

module tcm_prescaler
  import tcm_pkg::*;
#(
  parameter int PRE_W = PRESCALE_W
)
(
  input wire logic clk_sys_i,
  input wire logic srst_i,
  input wire tcm_clock_select_type clock_select_i,
  input wire logic ext_clk_i,
  output logic tick_o
);

  // ----------------------------------------------------------------
  // Elaboration check
  // ----------------------------------------------------------------
  if (PRE_W != PRESCALE_W)
  begin : g_bad_width
    $error("tcm_prescaler: PRE_W must equal PRESCALE_W");
  end

  logic [PRE_W-1:0] div_q;
  logic ext_prev_q;

  // ----------------------------------------------------------------
  // Free-running divider
  // ----------------------------------------------------------------
  // Shared free run: a mode change can give one short first period
  always_ff @(posedge clk_sys_i)
  begin
    if (srst_i)
      div_q <= '0;
    else
      div_q <= div_q + 1'b1;
  end

  always_ff @(posedge clk_sys_i)
  begin
    // Track the pin during reset, so no false edge follows release
    if (srst_i)
      ext_prev_q <= ext_clk_i;
    else
      ext_prev_q <= ext_clk_i;
  end

  // ----------------------------------------------------------------
  // Tap select, one-cycle enable
  // ----------------------------------------------------------------
  always_comb
  begin
    unique case (clock_select_i)
      CS_STOP: tick_o = 1'b0;
      CS_DIV1: tick_o = 1'b1;
      CS_DIV8: tick_o = (div_q & DIV8_MASK) == DIV8_MASK;
      CS_DIV64: tick_o = (div_q & DIV64_MASK) == DIV64_MASK;
      CS_DIV256: tick_o = (div_q & DIV256_MASK) == DIV256_MASK;
      CS_DIV1024: tick_o = (div_q & DIV1024_MASK) == DIV1024_MASK;
      CS_EXT_FALL: tick_o = ext_prev_q & ~ext_clk_i;
      CS_EXT_RISE: tick_o = ~ext_prev_q & ext_clk_i;
    endcase
  end

endmodule

// file: hw/tcm_timer8.sv
`timescale 1ns/10ps


module tcm_timer8
  import tcm_pkg::*;
#(
  parameter int WIDTH = CNT_W
)
(
  input wire logic clk_sys_i,
  input wire logic srst_i,
  input wire tcm_ctrl_type ctrl_i,
  input wire logic ext_clk_i,
  input wire logic count_wr_i,
  input wire logic [WIDTH-1:0] count_wdata_i,
  input wire logic compare_wr_i,
  input wire logic [WIDTH-1:0] compare_wdata_i,
  input wire logic force_compare_strobe_i,
  input wire tcm_flags_type flag_clr_i,
  input wire tcm_flags_type irq_ack_i,
  input wire logic compare_irq_enable_i,
  input wire logic overflow_irq_enable_i,
  input wire logic port_data_i,
  input wire logic output_pin_direction_bit_i,
  output logic [WIDTH-1:0] count_value_o,
  output logic [WIDTH-1:0] compare_value_o,
  output tcm_flags_type flags_o,
  output logic compare_output_o,
  output logic compare_irq_o,
  output logic overflow_irq_o,
  output logic pin_o,
  output logic pin_oe_o
);

  // ----------------------------------------------------------------
  // Elaboration check
  // ----------------------------------------------------------------
  if (WIDTH != CNT_W)
  begin : g_bad_width
    $error("tcm_timer8: WIDTH must equal CNT_W");
  end

  if (CNT_MAX != {CNT_W{1'b1}})
  begin : g_bad_max
    $error("tcm_timer8: CNT_MAX must be all ones");
  end

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  logic tick;
  logic [WIDTH-1:0] count_q;
  logic [WIDTH-1:0] count_d;
  logic [WIDTH-1:0] compare_q;
  logic [WIDTH-1:0] compare_buf_q;
  logic block_q;
  logic oc_q;
  logic oc_d;
  logic ovf_q;
  logic cmp_q;
  logic is_pwm;
  logic is_ctc;
  logic at_max;
  logic equal;
  logic match;
  logic wrap;
  logic apply_action;
  logic match_act;
  logic force_act;
  logic ovf_set;
  logic cmp_set;
  logic ovf_clr;
  logic cmp_clr;

  // ----------------------------------------------------------------
  // Timer clock enable
  // ----------------------------------------------------------------
  tcm_prescaler #(
    .PRE_W(PRESCALE_W)
  ) u_prescaler (
    .clk_sys_i(clk_sys_i),
    .srst_i(srst_i),
    .clock_select_i(ctrl_i.clock_select),
    .ext_clk_i(ext_clk_i),
    .tick_o(tick)
  );

  // ----------------------------------------------------------------
  // Mode decode
  // ----------------------------------------------------------------
  // Only the waveform mode enters here, never the output mode
  always_comb
  begin
    unique case (ctrl_i.waveform_gen_mode)
      WGM_NORMAL:
      begin
        is_pwm = 1'b0;
        is_ctc = 1'b0;
      end
      WGM_CTC:
      begin
        is_pwm = 1'b0;
        is_ctc = 1'b1;
      end
      WGM_PC_PWM, WGM_FAST_PWM:
      begin
        is_pwm = 1'b1;
        is_ctc = 1'b0;
      end
    endcase
  end

  // ----------------------------------------------------------------
  // Comparator and match qualification
  // ----------------------------------------------------------------
  assign at_max = (count_q == CNT_MAX);
  assign equal = (count_q == compare_q);

  // Blocked match is simply lost, not deferred
  assign match = tick & equal & ~block_q;

  // Counter goes from max to bottom on this tick
  assign wrap = tick & at_max & ~count_wr_i;

  // ----------------------------------------------------------------
  // Write block, held until the next timer tick consumes it
  // ----------------------------------------------------------------
  // Held while stopped, so a write before start still blocks the match on the first tick
  always_ff @(posedge clk_sys_i)
  begin
    if (srst_i)
      block_q <= 1'b0;
    else if (count_wr_i)
      block_q <= 1'b1;
    else if (tick)
      block_q <= 1'b0;
  end

  // ----------------------------------------------------------------
  // Counter next value
  // ----------------------------------------------------------------
  // PWM sequences are outside this block; they run as plain up-count
  always_comb
  begin
    count_d = count_q;
    if (count_wr_i)
      count_d = count_wdata_i;
    else if (tick)
    begin
      if (is_ctc && match)
        count_d = CNT_BOTTOM;
      else
        count_d = count_q + 1'b1;
    end
  end

  always_ff @(posedge clk_sys_i)
  begin
    if (srst_i)
      count_q <= COUNT_RST;
    else
      count_q <= count_d;
  end

  // ----------------------------------------------------------------
  // Compare value: direct in non-PWM modes, buffered in PWM modes
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys_i)
  begin
    if (srst_i)
      compare_buf_q <= COMPARE_RST;
    else if (compare_wr_i)
      compare_buf_q <= compare_wdata_i;
  end

  // Unbuffered write can land below count: top is then missed
  always_ff @(posedge clk_sys_i)
  begin
    if (srst_i)
      compare_q <= COMPARE_RST;
    else if (!is_pwm && compare_wr_i)
      compare_q <= compare_wdata_i;
    else if (is_pwm && wrap)
      compare_q <= compare_buf_q;
    else if (!is_pwm)
      compare_q <= compare_buf_q;
  end

  // ----------------------------------------------------------------
  // Output action decode
  // ----------------------------------------------------------------
  // Mode bits read live, so a new setting acts on the next match
  assign match_act = !is_pwm && match;
  // Forced compare is dropped in PWM modes and never reaches the flags
  assign force_act = !is_pwm && force_compare_strobe_i;
  assign apply_action = match_act | force_act;

  always_comb
  begin
    oc_d = oc_q;
    if (apply_action)
    begin
      unique case (ctrl_i.compare_output_mode)
        COM_NONE: oc_d = oc_q;
        COM_TOGGLE: oc_d = ~oc_q;
        COM_CLEAR: oc_d = 1'b0;
        COM_SET: oc_d = 1'b1;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Output state
  // ----------------------------------------------------------------
  // Not reset on mode change, only on system reset
  always_ff @(posedge clk_sys_i)
  begin
    if (srst_i)
      oc_q <= OC_RST;
    else
      oc_q <= oc_d;
  end

  // ----------------------------------------------------------------
  // Overflow flag
  // ----------------------------------------------------------------
  assign ovf_set = wrap;
  assign ovf_clr = flag_clr_i.overflow_flag | irq_ack_i.overflow_flag;

  // Set wins so an overflow in the clearing cycle is kept
  always_ff @(posedge clk_sys_i)
  begin
    if (srst_i)
      ovf_q <= 1'b0;
    else if (ovf_set)
      ovf_q <= 1'b1;
    else if (ovf_clr)
      ovf_q <= 1'b0;
  end

  // ----------------------------------------------------------------
  // Compare flag
  // ----------------------------------------------------------------
  // Forced compare never reaches here
  assign cmp_set = match;
  assign cmp_clr = flag_clr_i.compare_flag | irq_ack_i.compare_flag;

  always_ff @(posedge clk_sys_i)
  begin
    if (srst_i)
      cmp_q <= 1'b0;
    else if (cmp_set)
      cmp_q <= 1'b1;
    else if (cmp_clr)
      cmp_q <= 1'b0;
  end

  // ----------------------------------------------------------------
  // Status and request outputs
  // ----------------------------------------------------------------
  assign count_value_o = count_q;
  assign compare_value_o = compare_q;
  // One driver for the whole flag struct
  always_comb
  begin
    flags_o.overflow_flag = ovf_q;
    flags_o.compare_flag = cmp_q;
  end
  assign compare_output_o = oc_q;
  assign compare_irq_o = cmp_q & compare_irq_enable_i;
  assign overflow_irq_o = ovf_q & overflow_irq_enable_i;

  // ----------------------------------------------------------------
  // Port pin override
  // ----------------------------------------------------------------
  // Override ignores waveform mode; direction always from port
  always_comb
  begin
    if (ctrl_i.compare_output_mode != COM_NONE)
      pin_o = oc_q;
    else
      pin_o = port_data_i;
  end

  assign pin_oe_o = output_pin_direction_bit_i;

endmodule

// file: bench/tcm_port_model.sv
`timescale 1ns/10ps

module tcm_port_model
(
  input wire logic pin_i,
  input wire logic pin_oe_i,
  output logic pad_o
);
  // Pull-up holds the pad high while the pin is an input
  assign pad_o = pin_oe_i ? pin_i : 1'b1;
endmodule

// file: bench/tcm_timer8_sva.sv
`timescale 1ns/10ps

module tcm_timer8_sva
  import tcm_pkg::*;
#(
  parameter int WIDTH = CNT_W
)
(
  input wire logic clk_sys_i,
  input wire logic srst_i,
  input wire tcm_ctrl_type ctrl_i,
  input wire logic count_wr_i,
  input wire logic [WIDTH-1:0] count_wdata_i,
  input wire logic compare_wr_i,
  input wire logic force_compare_strobe_i,
  input wire tcm_flags_type irq_ack_i,
  input wire logic port_data_i,
  input wire logic output_pin_direction_bit_i,
  input wire logic [WIDTH-1:0] count_value_o,
  input wire logic [WIDTH-1:0] compare_value_o,
  input wire tcm_flags_type flags_o,
  input wire logic compare_output_o,
  input wire logic pin_o,
  input wire logic pin_oe_o
);
  default clocking cb @(posedge clk_sys_i);
  endclocking
  default disable iff (srst_i);
  logic stop;
  logic run1;
  logic clear_on_match_mode;
  assign stop = ctrl_i.clock_select == CS_STOP;
  assign run1 = ctrl_i.clock_select == CS_DIV1;
  assign clear_on_match_mode = ctrl_i.waveform_gen_mode == WGM_CTC;

  chk_reset_clear: assert property (disable iff (1'b0) srst_i |=> count_value_o == 8'h00
    && compare_value_o == 8'h00 && flags_o == 2'b00 && !compare_output_o)
    else $error("reset state wrong");
  chk_pin_select: assert property (pin_o == ((ctrl_i.compare_output_mode != COM_NONE)
    ? compare_output_o : port_data_i)) else $error("pin source wrong");
  chk_pin_dir: assert property (pin_oe_o == output_pin_direction_bit_i)
    else $error("pin direction wrong");
  chk_write_wins: assert property (count_wr_i |=> count_value_o == $past(count_wdata_i))
    else $error("count write lost");
  chk_force_only: assert property (stop && force_compare_strobe_i && !count_wr_i |=>
    $stable(count_value_o) && (!flags_o.compare_flag || $past(flags_o.compare_flag)))
    else $error("force touched counter or flag");
  chk_force_toggle: assert property (stop && force_compare_strobe_i
    && !ctrl_i.waveform_gen_mode[0] && ctrl_i.compare_output_mode == COM_TOGGLE
    |=> compare_output_o != $past(compare_output_o)) else $error("force no toggle");
  chk_com_hold: assert property (ctrl_i.compare_output_mode == COM_NONE
    |=> $stable(compare_output_o)) else $error("output moved in mode zero");
  chk_ctc_clear: assert property (run1 && $past(ctrl_i.clock_select) == CS_DIV1 && clear_on_match_mode
    && count_value_o == compare_value_o && !count_wr_i && !$past(count_wr_i)
    |=> count_value_o == 8'h00 && flags_o.compare_flag) else $error("no clear at top");
  chk_normal_wrap: assert property (run1 && ctrl_i.waveform_gen_mode == WGM_NORMAL
    && count_value_o == 8'hff && !count_wr_i |=> count_value_o == 8'h00
    && flags_o.overflow_flag) else $error("wrap or overflow wrong");
  chk_ovf_ack: assert property (stop && irq_ack_i.overflow_flag
    |=> !flags_o.overflow_flag) else $error("overflow not cleared");
  chk_write_block: assert property ((count_wr_i && run1 && clear_on_match_mode && !compare_wr_i
    && count_wdata_i == compare_value_o) ##1 (run1 && !count_wr_i && !compare_wr_i)
    |=> count_value_o == compare_value_o + 8'h01) else $error("match not blocked");
endmodule

bind tcm_timer8 tcm_timer8_sva #(.WIDTH(WIDTH)) u_sva (.clk_sys_i, .srst_i, .ctrl_i,
  .count_wr_i, .count_wdata_i, .compare_wr_i, .force_compare_strobe_i, .irq_ack_i,
  .port_data_i, .output_pin_direction_bit_i, .count_value_o, .compare_value_o,
  .flags_o, .compare_output_o, .pin_o, .pin_oe_o);

// file: bench/tb_top.sv
`timescale 1ns/10ps

module tb_top
  import tcm_pkg::*;
;
  logic clk_sys_i = 1'b0;
  logic srst_i;
  tcm_ctrl_type ctrl_i;
  logic ext_clk_i, count_wr_i, compare_wr_i, force_compare_strobe_i;
  logic [7:0] count_wdata_i, compare_wdata_i, count_value_o, compare_value_o;
  tcm_flags_type flag_clr_i, irq_ack_i, flags_o;
  logic port_data_i, output_pin_direction_bit_i, compare_output_o, pin_o, pin_oe_o, pad;
  logic s;
  logic compare_irq_enable_i, overflow_irq_enable_i, compare_irq_o, overflow_irq_o;
  int err_total, checks, i, n;
  tcm_com_type com_tab[4] = '{COM_SET, COM_NONE, COM_CLEAR, COM_TOGGLE};
  logic [3:0] oc_tab = 4'b1011;

  tcm_timer8 dut (.clk_sys_i, .srst_i, .ctrl_i, .ext_clk_i, .count_wr_i, .count_wdata_i,
    .compare_wr_i, .compare_wdata_i, .force_compare_strobe_i, .flag_clr_i, .irq_ack_i,
    .compare_irq_enable_i, .overflow_irq_enable_i, .port_data_i,
    .output_pin_direction_bit_i, .count_value_o, .compare_value_o, .flags_o,
    .compare_output_o, .compare_irq_o, .overflow_irq_o, .pin_o, .pin_oe_o);
  tcm_port_model u_port (.pin_i(pin_o), .pin_oe_i(pin_oe_o), .pad_o(pad));

  always #25 clk_sys_i = ~clk_sys_i;

  // ----------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------
  task print_verdict;
    $display("checks=%0d err_total=%0d", checks, err_total);
    if (err_total == 0 && checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  task chk(input logic [7:0] got, input logic [7:0] exp);
    checks++;
    if (got !== exp)
    begin
      err_total++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // Bounded waits end the run rather than hang
  task bound(input int cnt, input int lim);
    if (cnt >= lim)
    begin
      err_total++;
      $display("BAD t=%0t wait=%h lim=%h", $time, cnt, lim);
      print_verdict();
    end
  endtask

  task set_ctrl(input tcm_clock_select_type cs, input tcm_wgm_type w, input tcm_com_type c);
    @(negedge clk_sys_i);
    ctrl_i = '{cs, w, c};
  endtask

  // Kind: 0 count, 1 compare, 2 force, 3 flag clear, 4 overflow ack
  task wr(input int k, input logic [7:0] d);
    @(negedge clk_sys_i);
    count_wdata_i = d;
    compare_wdata_i = d;
    count_wr_i = (k == 0);
    compare_wr_i = (k == 1);
    force_compare_strobe_i = (k == 2);
    flag_clr_i = (k == 3) ? 2'b11 : 2'b00;
    irq_ack_i = (k == 4) ? 2'b10 : 2'b00;
    @(negedge clk_sys_i);
    count_wr_i = 1'b0;
    compare_wr_i = 1'b0;
    force_compare_strobe_i = 1'b0;
    flag_clr_i = 2'b00;
    irq_ack_i = 2'b00;
  endtask

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial
  begin
    srst_i = 1'b1;
    ctrl_i = '{CS_STOP, WGM_NORMAL, COM_NONE};
    ext_clk_i = 1'b0;
    port_data_i = 1'b1;
    output_pin_direction_bit_i = 1'b0;
    compare_irq_enable_i = 1'b1;
    overflow_irq_enable_i = 1'b1;
    wr(5, 8'h00);
    repeat (8) @(negedge clk_sys_i);
    srst_i = 1'b0;
    chk(count_value_o, 8'h00);
    chk({6'h00, flags_o, compare_output_o}, 8'h00);
    $display("test reset done");
    for (i = 0; i < 4; i++)
    begin
      set_ctrl(CS_STOP, WGM_NORMAL, com_tab[i]);
      wr(2, 8'h00);
      chk({7'h00, compare_output_o}, {7'h00, oc_tab[i]});
      chk({flags_o, count_value_o[5:0]}, 8'h00);
    end
    chk({7'h00, pad}, 8'h01);
    output_pin_direction_bit_i = 1'b1;
    port_data_i = 1'b0;
    #1 chk({6'h00, pin_oe_o, pad}, 8'h03);
    set_ctrl(CS_STOP, WGM_CTC, COM_NONE);
    #1 chk({6'h00, compare_output_o, pad}, 8'h02);
    $display("test output done");
    set_ctrl(CS_STOP, WGM_NORMAL, COM_NONE);
    wr(0, 8'hfe);
    chk(count_value_o, 8'hfe);
    set_ctrl(CS_DIV1, WGM_NORMAL, COM_NONE);
    for (n = 0; n < 8 && !flags_o.overflow_flag; n++) @(negedge clk_sys_i);
    bound(n, 8);
    chk(count_value_o, 8'h00);
    chk({6'h00, compare_irq_o, overflow_irq_o}, 8'h01);
    set_ctrl(CS_STOP, WGM_NORMAL, COM_NONE);
    wr(4, 8'h00);
    chk({7'h00, flags_o.overflow_flag}, 8'h00);
    s = count_value_o[0];
    repeat (4) @(negedge clk_sys_i);
    chk({7'h00, count_value_o[0]}, {7'h00, s});
    $display("test normal done");
    set_ctrl(CS_STOP, WGM_CTC, COM_TOGGLE);
    wr(1, 8'h02);
    wr(0, 8'h00);
    wr(3, 8'h00);
    set_ctrl(CS_DIV1, WGM_CTC, COM_TOGGLE);
    s = compare_output_o;
    for (n = 0; n < 10 && compare_output_o === s; n++) @(negedge clk_sys_i);
    bound(n, 10);
    s = compare_output_o;
    for (n = 0; n < 10 && compare_output_o === s; n++) @(negedge clk_sys_i);
    bound(n, 10);
    chk(n[7:0], 8'h03);
    chk({7'h00, flags_o.compare_flag}, 8'h01);
    chk({6'h00, compare_irq_o, overflow_irq_o}, 8'h02);
    compare_irq_enable_i = 1'b0;
    #1 chk({6'h00, compare_irq_o, overflow_irq_o}, 8'h00);
    compare_irq_enable_i = 1'b1;
    wr(0, 8'h02);
    chk(count_value_o, 8'h02);
    @(negedge clk_sys_i);
    chk(count_value_o, 8'h03);
    set_ctrl(CS_STOP, WGM_CTC, COM_TOGGLE);
    wr(3, 8'h00);
    chk({7'h00, flags_o.compare_flag}, 8'h00);
    $display("test ctc done");
    wr(0, 8'h05);
    set_ctrl(CS_DIV1, WGM_CTC, COM_TOGGLE);
    s = 1'b0;
    for (n = 0; n < 300 && count_value_o !== 8'h00; n++)
    begin
      @(negedge clk_sys_i);
      if (count_value_o === 8'hff)
        s = 1'b1;
    end
    bound(n, 300);
    chk({7'h00, s}, 8'h01);
    $display("test late top done");
    set_ctrl(CS_DIV8, WGM_CTC, COM_TOGGLE);
    s = compare_output_o;
    for (n = 0; n < 60 && compare_output_o === s; n++) @(negedge clk_sys_i);
    bound(n, 60);
    s = compare_output_o;
    for (n = 0; n < 60 && compare_output_o === s; n++) @(negedge clk_sys_i);
    bound(n, 60);
    chk(n[7:0], 8'h18);
    $display("test prescale done");
    set_ctrl(CS_EXT_RISE, WGM_NORMAL, COM_NONE);
    wr(0, 8'h40);
    for (i = 0; i < 6; i++) @(negedge clk_sys_i) ext_clk_i = ~ext_clk_i;
    @(negedge clk_sys_i);
    chk(count_value_o, 8'h43);
    set_ctrl(CS_STOP, WGM_FAST_PWM, COM_TOGGLE);
    s = compare_output_o;
    wr(2, 8'h00);
    chk({7'h00, compare_output_o}, {7'h00, s});
    $display("test clock source done");
    set_ctrl(CS_STOP, WGM_NORMAL, COM_SET);
    wr(2, 8'h00);
    chk({7'h00, compare_output_o}, 8'h01);
    srst_i = 1'b1;
    repeat (2) @(negedge clk_sys_i);
    srst_i = 1'b0;
    chk({compare_output_o, flags_o, count_value_o[4:0]}, 8'h00);
    $display("test mid reset done");
    print_verdict();
  end
endmodule
